// [hdl/gas_bank_params.svh]
/*
 Offsets, reset values and bus constants of the gas sensor register bank.
 Assumes inclusion by the modules that need these values; the package does not include it.
*/
`ifndef GAS_BANK_PARAMS_SVH
`define GAS_BANK_PARAMS_SVH
`define SLAVE_ADDR 7'h41
`define IDX_GAS_LEVEL 8'h02
`define IDX_SMOOTHING 8'h04
`define IDX_CAL_TRIGGER 8'h05
`define IDX_INIT_BG 8'h06
`define IDX_RECUR_BG 8'h08
`define IDX_BG_TARGET 8'h0C
`define IDX_FRESH_TARGET 8'h12
`define IDX_KNOWN_TARGET 8'h14
`define IDX_ALTITUDE 8'h1E
`define IDX_SERIAL 8'h26
`define IDX_BG_CONTROL 8'h4E
`define RST_SMOOTHING 8'h10
`define RST_INIT_BG 16'h2F40
`define RST_RECUR_BG 16'h3600
`define RST_BG_TARGET 16'h0190
`define RST_FRESH_TARGET 16'h0190
`define RST_KNOWN_TARGET 16'h0000
`define RST_ALTITUDE 16'h2000
`define RST_BG_CONTROL 8'h02
`define BG_ENABLED 8'h02
`define CAL_FRESH_BIT 0
`define CAL_KNOWN_VALUE 8'h02
`endif

// [hdl/gas_bank_pkg.sv]
/*
 Types shared by the gas sensor register bank modules.
 Assumes the params header for numeric constants.
*/
package gas_bank_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INDEX, ST_WDATA, ST_DACK, ST_RDATA, ST_RACK
    } link_state_e;
    typedef logic [7:0] byte_t;
endpackage : gas_bank_pkg

// [hdl/reg_port_if.sv]
/*
 Byte-wide register access port between the serial engine and the register file.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface reg_port_if;
    logic [7:0] index;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] rdata;
    modport engine (output index, output wdata, output wr, input rdata);
    modport regs (input index, input wdata, input wr, output rdata);
endinterface : reg_port_if

// [hdl/gas_reg_file.sv]
/*
 Register file of the gas sensor, byte addressed by register index.
 Assumes writes arrive as one-cycle strobes on the register port.
*/
`timescale 1ns/100ps
`include "gas_bank_params.svh"
module gas_reg_file
    import gas_bank_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port
    reg_port_if.regs port,
    // Device side
    input wire logic [15:0] gas_level,
    input wire logic [31:0] unit_serial,
    output logic [7:0] smoothing,
    output logic [15:0] init_bg_interval,
    output logic [15:0] recur_bg_interval,
    output logic [15:0] bg_target,
    output logic [15:0] fresh_target,
    output logic [15:0] known_target,
    output logic [15:0] altitude,
    output logic [7:0] bg_control,
    output logic fresh_cal,
    output logic known_cal,
    output logic recur_written
);
    logic [7:0] smooth_q, smooth_d, bgc_q, bgc_d;
    logic [15:0] init_q, init_d, recur_q, recur_d, bgt_q, bgt_d;
    logic [15:0] fresh_q, fresh_d, known_q, known_d, alt_q, alt_d;
    logic fcal_q, fcal_d, kcal_q, kcal_d, rw_q, rw_d;
    logic [7:0] rd;
    logic [7:0] ix;

    assign ix = port.index;

    // Byte update of a 16-bit register, high byte at the even index
    function automatic logic [15:0] put16(input logic [15:0] cur, input logic hi,
                                          input logic [7:0] b);
        put16 = hi ? {b, cur[7:0]} : {cur[15:8], b};
    endfunction : put16

    always_comb begin
        smooth_d = smooth_q;
        bgc_d = bgc_q;
        init_d = init_q;
        recur_d = recur_q;
        bgt_d = bgt_q;
        fresh_d = fresh_q;
        known_d = known_q;
        alt_d = alt_q;
        fcal_d = 1'b0;
        kcal_d = 1'b0;
        rw_d = 1'b0;
        if (port.wr) begin
            case (ix)
                `IDX_SMOOTHING: smooth_d = port.wdata;
                `IDX_CAL_TRIGGER: begin
                    fcal_d = port.wdata[`CAL_FRESH_BIT];
                    kcal_d = (port.wdata == `CAL_KNOWN_VALUE);
                end
                `IDX_INIT_BG: init_d = put16(init_q, 1'b1, port.wdata);
                `IDX_INIT_BG + 8'h01: init_d = put16(init_q, 1'b0, port.wdata);
                `IDX_RECUR_BG: begin
                    recur_d = put16(recur_q, 1'b1, port.wdata);
                end
                `IDX_RECUR_BG + 8'h01: begin
                    recur_d = put16(recur_q, 1'b0, port.wdata);
                    rw_d = 1'b1;
                end
                `IDX_BG_TARGET: bgt_d = put16(bgt_q, 1'b1, port.wdata);
                `IDX_BG_TARGET + 8'h01: bgt_d = put16(bgt_q, 1'b0, port.wdata);
                `IDX_FRESH_TARGET: fresh_d = put16(fresh_q, 1'b1, port.wdata);
                `IDX_FRESH_TARGET + 8'h01: fresh_d = put16(fresh_q, 1'b0, port.wdata);
                `IDX_KNOWN_TARGET: known_d = put16(known_q, 1'b1, port.wdata);
                `IDX_KNOWN_TARGET + 8'h01: known_d = put16(known_q, 1'b0, port.wdata);
                `IDX_ALTITUDE: alt_d = put16(alt_q, 1'b1, port.wdata);
                `IDX_ALTITUDE + 8'h01: alt_d = put16(alt_q, 1'b0, port.wdata);
                `IDX_BG_CONTROL: bgc_d = port.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            smooth_q <= `RST_SMOOTHING;
            bgc_q <= `RST_BG_CONTROL;
            init_q <= `RST_INIT_BG;
            recur_q <= `RST_RECUR_BG;
            bgt_q <= `RST_BG_TARGET;
            fresh_q <= `RST_FRESH_TARGET;
            known_q <= `RST_KNOWN_TARGET;
            alt_q <= `RST_ALTITUDE;
            fcal_q <= 1'b0;
            kcal_q <= 1'b0;
            rw_q <= 1'b0;
        end else begin
            smooth_q <= smooth_d;
            bgc_q <= bgc_d;
            init_q <= init_d;
            recur_q <= recur_d;
            bgt_q <= bgt_d;
            fresh_q <= fresh_d;
            known_q <= known_d;
            alt_q <= alt_d;
            fcal_q <= fcal_d;
            kcal_q <= kcal_d;
            rw_q <= rw_d;
        end
    end

    // Read mux, zero for unlisted and write-only indices
    always_comb begin
        case (ix)
            `IDX_GAS_LEVEL: rd = gas_level[15:8];
            `IDX_GAS_LEVEL + 8'h01: rd = gas_level[7:0];
            `IDX_SMOOTHING: rd = smooth_q;
            `IDX_INIT_BG: rd = init_q[15:8];
            `IDX_INIT_BG + 8'h01: rd = init_q[7:0];
            `IDX_RECUR_BG: rd = recur_q[15:8];
            `IDX_RECUR_BG + 8'h01: rd = recur_q[7:0];
            `IDX_BG_TARGET: rd = bgt_q[15:8];
            `IDX_BG_TARGET + 8'h01: rd = bgt_q[7:0];
            `IDX_FRESH_TARGET: rd = fresh_q[15:8];
            `IDX_FRESH_TARGET + 8'h01: rd = fresh_q[7:0];
            `IDX_KNOWN_TARGET: rd = known_q[15:8];
            `IDX_KNOWN_TARGET + 8'h01: rd = known_q[7:0];
            `IDX_ALTITUDE: rd = alt_q[15:8];
            `IDX_ALTITUDE + 8'h01: rd = alt_q[7:0];
            `IDX_SERIAL: rd = unit_serial[31:24];
            `IDX_SERIAL + 8'h01: rd = unit_serial[23:16];
            `IDX_SERIAL + 8'h02: rd = unit_serial[15:8];
            `IDX_SERIAL + 8'h03: rd = unit_serial[7:0];
            `IDX_BG_CONTROL: rd = bgc_q;
            default: rd = 8'h00;
        endcase
    end
    assign port.rdata = rd;

    assign smoothing = smooth_q;
    assign init_bg_interval = init_q;
    assign recur_bg_interval = recur_q;
    assign bg_target = bgt_q;
    assign fresh_target = fresh_q;
    assign known_target = known_q;
    assign altitude = alt_q;
    assign bg_control = bgc_q;
    assign fresh_cal = fcal_q;
    assign known_cal = kcal_q;
    assign recur_written = rw_q;

    chk_known_pulse: assert property (@(posedge clock) disable iff (!resetn)
        (port.wr && ix == `IDX_CAL_TRIGGER && port.wdata == 8'h02) |=> known_cal && !fresh_cal)
        else $error("known-gas trigger missing");
    chk_fresh_pulse: assert property (@(posedge clock) disable iff (!resetn)
        (port.wr && ix == `IDX_CAL_TRIGGER && port.wdata[0]) |=> fresh_cal ##1 !fresh_cal)
        else $error("fresh-air trigger not one cycle");
    chk_smooth_hold: assert property (@(posedge clock) disable iff (!resetn)
        !(port.wr && ix == `IDX_SMOOTHING) |=> $stable(smoothing))
        else $error("smoothing changed without write");
    chk_ro_ignore: assert property (@(posedge clock) disable iff (!resetn)
        (port.wr && ix == `IDX_GAS_LEVEL) |=> $stable(bg_control) && $stable(altitude))
        else $error("read-only write disturbed state");
endmodule : gas_reg_file

// [hdl/gas_i2c_bank.sv]
/*
 I2C slave register bank of a gas sensor: framing, index, byte transfer.
 Assumes SCL and SDA already synchronous to clock and the pad resolves drive.
*/
`timescale 1ns/100ps
`include "gas_bank_params.svh"
// Functional notes
// - Read: START, index, then one or more data bytes out, then STOP; the engine keeps sending bytes while the host acknowledges.
// - Index 0x02 returns measured gas level, two bytes, high byte first.
// - Index 0x04 holds smoothing byte, range 1 to 255, resets to 16.
// - Writing bit 0 set to 0x05 fires a fresh-air calibration pulse.
// - Writing 0x02 to 0x05 fires a known-gas calibration pulse.
// - Index 0x06 holds initial background interval, half-second units, reset 12096.
// - Index 0x08 holds recurring background interval, reset 13824.
// - Index 0x0C holds background target level, reset 400.
// - Index 0x12 holds fresh-air target level, reset 400.
// - Index 0x14 holds known-gas target, two bytes, high byte first.
// - Index 0x1E holds altitude correction, range 0 to 32768, reset 8192.
// - Index 0x26 returns the 32-bit serial number as four bytes.
// - Index 0x4E: 0x00 disables, 0x02 enables background calibration; reset enabled.
// - Answer only at seven-bit bus address 0x41.
// - Stray STOP mid-transfer returns the engine to idle; a stray START restarts the address phase.
module gas_i2c_bank
    import gas_bank_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // I2C pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Measurement side
    input wire logic [15:0] gas_level,
    input wire logic [31:0] unit_serial,
    // Configuration out
    output logic [7:0] smoothing,
    output logic [15:0] init_bg_interval,
    output logic [15:0] recur_bg_interval,
    output logic [15:0] bg_target,
    output logic [15:0] fresh_target,
    output logic [15:0] known_target,
    output logic [15:0] altitude,
    output logic bg_cal_enable,
    // Calibration events
    output logic fresh_cal,
    output logic known_cal,
    output logic force_bg_cal
);
    reg_port_if port ();

    link_state_e st_q, st_d;
    logic scl_q, sda_q;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] idx_q, idx_d;
    logic drv_q, drv_d;
    logic wr_q, wr_d;
    logic [7:0] wd_q, wd_d;
    logic rnw_q, rnw_d;
    logic recur_written;
    logic [7:0] bg_control;
    logic scl_rise, scl_fall, start_seen, stop_seen;

    // Bus condition detection on previous samples
    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign start_seen = scl_in && scl_q && sda_q && !sda_in;
    assign stop_seen = scl_in && scl_q && !sda_q && sda_in;

    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        idx_d = idx_q;
        drv_d = drv_q;
        wr_d = 1'b0;
        wd_d = wd_q;
        rnw_d = rnw_q;
        if (start_seen) begin
            st_d = ST_ADDR;
            bit_d = 3'h0;
            sh_d = 8'h00;
            drv_d = 1'b0;
        end else if (stop_seen) begin
            st_d = ST_IDLE;
            drv_d = 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: drv_d = 1'b0;
                ST_ADDR, ST_INDEX, ST_WDATA: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_in};
                        bit_d = bit_q + 3'h1;
                    end
                    if (scl_fall && bit_q == 3'h0 && st_q == ST_ADDR
                            && sh_q != 8'h00) begin
                        if (sh_q[7:1] == `SLAVE_ADDR) begin
                            rnw_d = sh_q[0];
                            drv_d = 1'b1;
                            st_d = ST_ADDR_ACK;
                        end else begin
                            st_d = ST_IDLE;
                        end
                    end else if (scl_fall && bit_q == 3'h0 && st_q == ST_INDEX) begin
                        idx_d = sh_q;
                        drv_d = 1'b1;
                        st_d = ST_DACK;
                    end else if (scl_fall && bit_q == 3'h0 && st_q == ST_WDATA) begin
                        wd_d = sh_q;
                        wr_d = 1'b1;
                        drv_d = 1'b1;
                        st_d = ST_DACK;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_d = 3'h0;
                        sh_d = 8'h00;
                        if (rnw_q) begin
                            sh_d = port.rdata;
                            drv_d = !port.rdata[7];
                            st_d = ST_RDATA;
                        end else begin
                            drv_d = 1'b0;
                            st_d = ST_INDEX;
                        end
                    end
                end
                ST_DACK: begin
                    if (scl_fall) begin
                        drv_d = 1'b0;
                        bit_d = 3'h0;
                        sh_d = 8'h00;
                        st_d = ST_WDATA;
                        if (wd_q != 8'h00 || idx_q != sh_q) begin
                            idx_d = idx_q;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            drv_d = 1'b0;
                            idx_d = idx_q + 8'h01;
                            st_d = ST_RACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            drv_d = !sh_q[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        rnw_d = !sda_in;
                    end
                    if (scl_fall) begin
                        if (rnw_q) begin
                            sh_d = port.rdata;
                            drv_d = !port.rdata[7];
                            bit_d = 3'h0;
                            st_d = ST_RDATA;
                        end else begin
                            st_d = ST_IDLE;
                        end
                    end
                end
                default: st_d = ST_IDLE;
            endcase
        end
        // Index advances after each written byte
        if (wr_q) begin
            idx_d = idx_q + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            idx_q <= 8'h00;
            drv_q <= 1'b0;
            wr_q <= 1'b0;
            wd_q <= 8'h00;
            rnw_q <= 1'b0;
        end else begin
            st_q <= st_d;
            scl_q <= scl_in;
            sda_q <= sda_in;
            bit_q <= bit_d;
            sh_q <= sh_d;
            idx_q <= idx_d;
            drv_q <= drv_d;
            wr_q <= wr_d;
            wd_q <= wd_d;
            rnw_q <= rnw_d;
        end
    end

    assign port.index = idx_q;
    assign port.wdata = wd_q;
    assign port.wr = wr_q;

    // Open drain: drive low only
    assign sda_out = 1'b0;
    assign sda_oe = drv_q;

    gas_reg_file u_regs (
        .clock(clock),
        .resetn(resetn),
        .port(port),
        .gas_level(gas_level),
        .unit_serial(unit_serial),
        .smoothing(smoothing),
        .init_bg_interval(init_bg_interval),
        .recur_bg_interval(recur_bg_interval),
        .bg_target(bg_target),
        .fresh_target(fresh_target),
        .known_target(known_target),
        .altitude(altitude),
        .bg_control(bg_control),
        .fresh_cal(fresh_cal),
        .known_cal(known_cal),
        .recur_written(recur_written)
    );

    assign bg_cal_enable = (bg_control == `BG_ENABLED);
    // Zero written to recurring interval while enabled forces calibration
    assign force_bg_cal = recur_written && recur_bg_interval == 16'h0000
                          && bg_cal_enable;

    // Framing checks
    chk_stop_idle: assert property (@(posedge clock) disable iff (!resetn)
        stop_seen |=> st_q == ST_IDLE && !sda_oe)
        else $error("stop did not return to idle");

    chk_start_addr: assert property (@(posedge clock) disable iff (!resetn)
        start_seen |=> st_q == ST_ADDR && !sda_oe)
        else $error("start did not restart address phase");

    chk_start_clear: assert property (@(posedge clock) disable iff (!resetn)
        start_seen |=> sh_q == 8'h00 && bit_q == 3'h0)
        else $error("start left stale shift state");

    chk_idle_release: assert property (@(posedge clock) disable iff (!resetn)
        st_q == ST_IDLE |-> !sda_oe)
        else $error("pin driven while idle");

    chk_addr_match: assert property (@(posedge clock) disable iff (!resetn)
        (st_q == ST_ADDR_ACK) |-> sda_oe && sh_q[7:1] == `SLAVE_ADDR)
        else $error("address ack missing");

    chk_foreign_addr: assert property (@(posedge clock) disable iff (!resetn)
        (st_q == ST_ADDR && scl_fall && bit_q == 3'h0 && sh_q != 8'h00
            && sh_q[7:1] != `SLAVE_ADDR)
        |=> st_q == ST_IDLE && !sda_oe)
        else $error("foreign address not ignored");

    // Read path checks
    chk_read_load: assert property (@(posedge clock) disable iff (!resetn)
        (st_q == ST_ADDR_ACK && rnw_q && scl_fall)
        |=> st_q == ST_RDATA && sh_q == $past(port.rdata))
        else $error("read byte not loaded");

    chk_read_shift: assert property (@(posedge clock) disable iff (!resetn)
        st_q == ST_RDATA |-> sda_oe == !sh_q[7])
        else $error("read bit not on the pin");

    chk_ack_release: assert property (@(posedge clock) disable iff (!resetn)
        st_q == ST_RACK |-> !sda_oe)
        else $error("pin held in host acknowledge");

    chk_read_incr: assert property (@(posedge clock) disable iff (!resetn)
        (st_q == ST_RDATA && st_d == ST_RACK && !start_seen && !stop_seen)
        |=> port.index == $past(port.index) + 8'h01)
        else $error("index not advanced on read");

    // Write path checks
    chk_write_ack: assert property (@(posedge clock) disable iff (!resetn)
        port.wr |-> st_q == ST_DACK && sda_oe)
        else $error("written byte not acknowledged");

    chk_write_incr: assert property (@(posedge clock) disable iff (!resetn)
        port.wr |=> port.index == $past(port.index) + 8'h01)
        else $error("index not advanced on write");

    chk_force_event: assert property (@(posedge clock) disable iff (!resetn)
        (port.wr && port.index == `IDX_RECUR_BG + 8'h01 && port.wdata == 8'h00
            && recur_bg_interval[15:8] == 8'h00 && bg_cal_enable)
        |=> force_bg_cal)
        else $error("forced calibration missing");
endmodule : gas_i2c_bank

// [bench/i2c_host_model.sv]
/*
 I2C host model: drives SCL, pulls SDA low, bit and byte tasks.
 Assumes SDA is resolved outside with a pull-up; all changes at clock fall.
*/
`timescale 1ns/100ps
module i2c_host_model (
    // Clock
    input wire logic clock,
    // Bus
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick

    // Start or repeated start
    task automatic start();
        sda_low = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
        tick(2);
    endtask : start

    // Stop
    task automatic stop();
        sda_low = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(4);
    endtask : stop

    // One SCL pulse; a 1 releases SDA
    task automatic clk_bit(input logic b, output logic r);
        sda_low = ~b;
        tick(2);
        scl = 1'b1;
        tick(2);
        r = sda;
        tick(2);
        scl = 1'b0;
        tick(2);
    endtask : clk_bit

    // Eight bits MSB first
    task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
    endtask : xfer_byte
endmodule : i2c_host_model

// [bench/test_gas_sensor_i2c_register_bank.sv]
/*
 Self-checking bench for the gas sensor I2C register bank.
 Assumes the host model, design package and params header are compiled.
*/
`timescale 1ns/100ps
`include "gas_bank_params.svh"
module test_gas_sensor_i2c_register_bank
    import gas_bank_pkg::*;
();
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic scl, sda_low, sda_in, sda_out, sda_oe, ack;
    logic [15:0] gas_level = 16'h0000;
    logic [31:0] unit_serial = 32'h0000_0000;
    logic [7:0] smoothing;
    logic [15:0] init_bg, recur_bg, bg_target, fresh_target, known_target, altitude;
    logic bg_cal_enable, fresh_cal, known_cal, force_bg_cal;
    logic [31:0] rd;
    int error_cnt = 0;
    int checks_done = 0;
    int fresh_n = 0, known_n = 0, force_n = 0;

    always #25 clock = ~clock;
    assign sda_in = ~(sda_low | (sda_oe & ~sda_out));

    gas_i2c_bank dut (
        .clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .gas_level(gas_level),
        .unit_serial(unit_serial), .smoothing(smoothing), .init_bg_interval(init_bg),
        .recur_bg_interval(recur_bg), .bg_target(bg_target),
        .fresh_target(fresh_target), .known_target(known_target), .altitude(altitude),
        .bg_cal_enable(bg_cal_enable), .fresh_cal(fresh_cal), .known_cal(known_cal),
        .force_bg_cal(force_bg_cal)
    );

    i2c_host_model host (.clock(clock), .sda(sda_in), .scl(scl), .sda_low(sda_low));

    // Pulse cycle counters
    always @(posedge clock) begin
        if (fresh_cal === 1'b1) fresh_n <= fresh_n + 1;
        if (known_cal === 1'b1) known_n <= known_n + 1;
        if (force_bg_cal === 1'b1) force_n <= force_n + 1;
    end

    task automatic check_value(input string what, input logic [31:0] exp,
                               input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check_value

    task automatic final_report();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // Byte out, device ack level left in ack
    task automatic send(input byte_t b);
        byte_t r;
        host.xfer_byte(b, r);
        host.clk_bit(1'b1, ack);
    endtask : send

    task automatic reg_write(input byte_t idx, input logic [31:0] d, input int n);
        host.start();
        send({`SLAVE_ADDR, 1'b0});
        check_value("write address ack", 32'h0, {31'h0, ack});
        send(idx);
        for (int i = n - 1; i >= 0; i--) send(d[8*i +: 8]);
        host.stop();
    endtask : reg_write

    task automatic reg_read(input byte_t idx, input int n, output logic [31:0] d);
        byte_t r;
        logic a;
        d = 32'h0;
        host.start();
        send({`SLAVE_ADDR, 1'b0});
        send(idx);
        host.start();
        send({`SLAVE_ADDR, 1'b1});
        check_value("read address ack", 32'h0, {31'h0, ack});
        for (int i = n - 1; i >= 0; i--) begin
            host.xfer_byte(8'hFF, r);
            host.clk_bit(i == 0, a);
            d[8*i +: 8] = r;
        end
        host.stop();
    endtask : reg_read

    task automatic test_resets();
        byte_t idx[8] = '{`IDX_SMOOTHING, `IDX_INIT_BG, `IDX_RECUR_BG, `IDX_BG_TARGET,
            `IDX_FRESH_TARGET, `IDX_KNOWN_TARGET, `IDX_ALTITUDE, `IDX_BG_CONTROL};
        logic [15:0] rst[8] = '{`RST_SMOOTHING, `RST_INIT_BG, `RST_RECUR_BG,
            `RST_BG_TARGET, `RST_FRESH_TARGET, `RST_KNOWN_TARGET, `RST_ALTITUDE,
            `RST_BG_CONTROL};
        int len[8] = '{1, 2, 2, 2, 2, 2, 2, 1};
        for (int i = 0; i < 8; i++) begin
            reg_read(idx[i], len[i], rd);
            check_value($sformatf("reset of %h", idx[i]), {16'h0, rst[i]}, rd);
        end
        check_value("bg enable", 32'h1, {31'h0, bg_cal_enable});
        check_value("altitude port", `RST_ALTITUDE, altitude);
        check_value("idle pin drive", 32'h0, {30'h0, sda_out, sda_oe});
    endtask : test_resets

    task automatic test_read_only();
        gas_level = 16'hA5C3;
        unit_serial = 32'h1357_9BDF;
        reg_read(`IDX_GAS_LEVEL, 2, rd);
        check_value("gas level", 32'hA5C3, rd);
        reg_read(`IDX_SERIAL, 4, rd);
        check_value("serial", 32'h1357_9BDF, rd);
        reg_read(`IDX_SERIAL, 1, rd);
        check_value("serial one byte", 32'h13, rd);
        reg_write(`IDX_GAS_LEVEL, 32'h1111, 2);
        reg_read(`IDX_GAS_LEVEL, 2, rd);
        check_value("gas level kept", 32'hA5C3, rd);
        reg_read(`IDX_CAL_TRIGGER, 1, rd);
        check_value("trigger read", 32'h0, rd);
        reg_read(8'h30, 2, rd);
        check_value("unlisted read", 32'h0, rd);
    endtask : test_read_only

    task automatic test_rw();
        reg_write(`IDX_SMOOTHING, 32'hFF, 1);
        reg_write(`IDX_ALTITUDE, 32'h8000, 2);
        reg_write(`IDX_FRESH_TARGET, 32'h01C2_04B0, 4);
        reg_write(`IDX_INIT_BG + 8'h01, 32'h5A, 1);
        reg_read(`IDX_FRESH_TARGET, 4, rd);
        check_value("targets", 32'h01C2_04B0, rd);
        reg_read(`IDX_ALTITUDE, 2, rd);
        check_value("altitude", 32'h8000, rd);
        check_value("smoothing port", 32'hFF, smoothing);
        check_value("known port", 32'h04B0, known_target);
        check_value("fresh port", 32'h01C2, fresh_target);
        check_value("init low byte", (`RST_INIT_BG & 16'hFF00) | 16'h005A, init_bg);
    endtask : test_rw

    task automatic test_calibration();
        reg_write(`IDX_CAL_TRIGGER, 32'h00, 1);
        reg_write(`IDX_CAL_TRIGGER, 32'h01, 1);
        reg_write(`IDX_CAL_TRIGGER, `CAL_KNOWN_VALUE, 1);
        reg_write(`IDX_CAL_TRIGGER, 32'h03, 1);
        check_value("fresh pulses", 32'd2, fresh_n);
        check_value("known pulses", 32'd1, known_n);
    endtask : test_calibration

    task automatic test_force_bg();
        reg_write(`IDX_BG_CONTROL, 32'h00, 1);
        check_value("bg disabled", 32'h0, {31'h0, bg_cal_enable});
        reg_write(`IDX_RECUR_BG, 32'h0000, 2);
        check_value("no force", 32'd0, force_n);
        reg_write(`IDX_BG_CONTROL, `BG_ENABLED, 1);
        reg_write(`IDX_BG_TARGET, 32'h01C2, 2);
        reg_write(`IDX_RECUR_BG, 32'h0000, 2);
        check_value("force pulses", 32'd1, force_n);
        check_value("bg target port", 32'h01C2, bg_target);
        check_value("recur port", 32'h0, recur_bg);
    endtask : test_force_bg

    task automatic test_bus_faults();
        host.start();
        send({`SLAVE_ADDR ^ 7'h01, 1'b0});
        check_value("foreign address", 32'h1, {31'h0, ack});
        host.stop();
        host.start();
        send({`SLAVE_ADDR, 1'b0});
        send(`IDX_SMOOTHING);
        for (int i = 0; i < 4; i++) host.clk_bit(1'b0, ack);
        host.stop();
        host.start();
        send({`SLAVE_ADDR, 1'b0});
        send(`IDX_SMOOTHING);
        for (int i = 0; i < 5; i++) host.clk_bit(1'b0, ack);
        host.start();
        host.stop();
        reg_read(`IDX_SMOOTHING, 1, rd);
        check_value("aborted writes", 32'hFF, rd);
    endtask : test_bus_faults

    initial begin
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        repeat (2) @(negedge clock);
        test_resets();
        test_read_only();
        test_rw();
        test_calibration();
        test_force_bg();
        test_bus_faults();
        final_report();
    end

    // Watchdog, about seven times the expected run
    initial begin
        #4_000_000;
        error_cnt++;
        final_report();
    end
endmodule : test_gas_sensor_i2c_register_bank
